/* File: hw/sfpi_pkg.sv */
// shared constants, types and shift helpers for the serial flash pin link
package sfpi_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCK_PERIOD_NS = 800;
  // host divider: half a link clock period in system clock cycles
  localparam int SCK_HALF_CYCLES = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int HALF_W = 4;
  localparam logic [HALF_W-1:0] HALF_LAST = HALF_W'(SCK_HALF_CYCLES - 1);

  localparam int NUM_LANES = 4;
  localparam int LANE_SI = 0;
  localparam int LANE_SO = 1;
  localparam int LANE_WG = 2;
  localparam int LANE_PR = 3;
  localparam logic PULL_LEVEL = 1'b1;

  localparam int PIN_SCK = 0;
  localparam int PIN_CSN = 1;
  localparam int PIN_IO = 2;
  localparam int PIN_W = 6;

  localparam int BYTE_W = 8;
  localparam logic [2:0] STEP_SINGLE = 3'h1;
  localparam logic [2:0] STEP_QUAD = 3'h4;
  localparam logic [2:0] CNT_ZERO = 3'h0;
  localparam logic [3:0] GROUPS_SINGLE = 4'h8;
  localparam logic [3:0] GROUPS_QUAD = 4'h2;
  localparam logic [3:0] GROUPS_LAST = 4'h1;
  localparam logic [3:0] OE_QUAD = 4'hF;
  localparam logic [3:0] OE_SINGLE = 4'h2;
  localparam logic [3:0] OE_NONE = 4'h0;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_TX = 4'h4;
  localparam logic [ADDR_W-1:0] REG_RX = 4'h8;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'hC;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CTRL_CS = 0;
  localparam int CTRL_QUAD = 1;
  localparam int CTRL_READ = 2;
  localparam int CTRL_WG_LOW = 3;
  localparam int CTRL_PR_LOW = 4;
  localparam int CTRL_W = 5;
  localparam int STAT_BUSY = 0;
  localparam int STAT_CS = 1;

  typedef enum logic [2:0] {
    SFPI_IDLE = 3'h1,
    SFPI_LOW = 3'h2,
    SFPI_HIGH = 3'h4
  } sfpi_host_state_type;

  function automatic logic [7:0] shift_in(input logic [7:0] sh,
                                          input logic bit_in,
                                          input logic [3:0] lanes,
                                          input logic quad);
    return quad ? {sh[3:0], lanes} : {sh[6:0], bit_in};
  endfunction : shift_in

  function automatic logic [7:0] shift_out(input logic [7:0] sh,
                                           input logic quad);
    return quad ? {sh[3:0], 4'h0} : {sh[6:0], 1'b0};
  endfunction : shift_out
endpackage : sfpi_pkg

/* File: hw/sfpi_if.sv */
// pin carrier between host controller and flash pin end
interface sfpi_if;
  logic sck;
  logic cs_n;
  logic [3:0] host_o;
  logic [3:0] host_oe;
  logic [3:0] dev_o;
  logic [3:0] dev_oe;
  logic [3:0] io;

  // undriven lanes read high, like the pull-ups on the pins
  for (genvar i = 0; i < sfpi_pkg::NUM_LANES; i++) begin : g_lane
    assign io[i] = dev_oe[i] ? dev_o[i] :
                   host_oe[i] ? host_o[i] : sfpi_pkg::PULL_LEVEL;
  end

  modport device (
    input sck,
    input cs_n,
    input io,
    output dev_o,
    output dev_oe
  );

  modport host (
    output sck,
    output cs_n,
    output host_o,
    output host_oe,
    input io
  );
endinterface : sfpi_if

/* File: hw/sfpi_device.sv */
// flash pin end: samples the link, shifts bytes, resolves multiplexed pins
//
// Behaviour
// - input bits captured on clock rising edge
// - output bits shifted on clock falling edge
// - input ignored while chip select high
// - outputs released while chip select high
// - write guard only with protect bits 0,1
// - guard pin low blocks status writes
// - quad mode makes guard pin lane two
// - guard pin pulled high when floating
// - lane-3 pin pauses when select is 0
// - lane-3 pin resets when select is 1
// - quad mode makes lane-3 pin data lane
// - pause keeps bit progress, transfer resumes
// - host pauses only with chip select low
// - pause starts on falling edge, clock low
// - pause ends on rising edge, clock low
// - pause pin pulled high when floating
// - operations framed by chip select edges
// - nothing decoded before first select fall
// - quad commands need quad enable set
module sfpi_device (
  input wire logic aclk,
  input wire logic aresetn,
  sfpi_if.device link,
  input wire logic quad_io_enable,
  input wire logic status_protect_bit_1,
  input wire logic status_protect_bit_0,
  input wire logic pause_or_restart_select,
  input wire logic quad_cmd,
  input wire logic tx_en,
  input wire logic [7:0] tx_data,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic selected,
  output logic paused,
  output logic hw_reset,
  output logic status_write_allowed
);
  logic [sfpi_pkg::PIN_W-1:0] pins;
  logic [sfpi_pkg::PIN_W-1:0] meta_r;
  logic [sfpi_pkg::PIN_W-1:0] sync_r;
  logic [sfpi_pkg::PIN_W-1:0] prev_r;
  logic [3:0] lanes;
  logic sck_s;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_high;
  logic pr_fall;
  logic pr_rise;
  logic armed_r;
  logic frame;
  logic qe_r;
  logic wg_role_r;
  logic pr_reset_role_r;
  logic pr_pause_role_r;
  logic paused_r;
  logic hw_reset_r;
  logic quad;
  logic active;
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic [7:0] rx_sh_r;
  logic [7:0] rx_sh_nxt;
  logic [7:0] tx_sh_r;
  logic [7:0] tx_sh_nxt;
  logic load_r;
  logic rx_valid_r;
  logic [7:0] rx_data_r;
  logic selected_r;
  logic swa_r;
  logic [3:0] dev_o_r;
  logic [3:0] dev_oe_r;

  assign pins = {link.io, link.cs_n, link.sck};

  // two-stage synchroniser; edges are found after the second stage only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= '1;
      sync_r <= '1;
      prev_r <= '1;
    end else begin
      meta_r <= pins;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign lanes = sync_r[sfpi_pkg::PIN_IO +: sfpi_pkg::NUM_LANES];
  assign sck_s = sync_r[sfpi_pkg::PIN_SCK];
  assign sck_rise = sck_s & ~prev_r[sfpi_pkg::PIN_SCK];
  assign sck_fall = ~sck_s & prev_r[sfpi_pkg::PIN_SCK];
  assign cs_high = sync_r[sfpi_pkg::PIN_CSN];
  assign cs_fall = ~cs_high & prev_r[sfpi_pkg::PIN_CSN];
  assign pr_fall = ~lanes[sfpi_pkg::LANE_PR] &
                   prev_r[sfpi_pkg::PIN_IO + sfpi_pkg::LANE_PR];
  assign pr_rise = lanes[sfpi_pkg::LANE_PR] &
                   ~prev_r[sfpi_pkg::PIN_IO + sfpi_pkg::LANE_PR];

  // a select already low at reset release still starts a frame, as the sync stages reset high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed_r <= 1'b0;
    end else if (hw_reset_r) begin
      armed_r <= 1'b0;
    end else if (cs_fall) begin
      armed_r <= 1'b1;
    end
  end

  assign frame = armed_r & ~cs_high;

  // roles follow the config only while deselected, frozen inside a frame
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      qe_r <= 1'b0;
      wg_role_r <= 1'b0;
      pr_reset_role_r <= 1'b0;
      pr_pause_role_r <= 1'b0;
    end else if (cs_high) begin
      qe_r <= quad_io_enable;
      wg_role_r <= ~quad_io_enable & ~status_protect_bit_1 &
                   status_protect_bit_0;
      pr_pause_role_r <= ~quad_io_enable &
                         ~pause_or_restart_select;
      pr_reset_role_r <= ~quad_io_enable &
                         pause_or_restart_select;
    end
  end

  // an open pin reads high through the pull-up, so it never protects
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      swa_r <= 1'b1;
    end else begin
      swa_r <= ~(wg_role_r & ~lanes[sfpi_pkg::LANE_WG]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hw_reset_r <= 1'b0;
    end else begin
      hw_reset_r <= pr_reset_role_r & ~lanes[sfpi_pkg::LANE_PR];
    end
  end

  // pause needs a frame; pin edges with the clock high are not accepted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      paused_r <= 1'b0;
    end else if (!frame || !pr_pause_role_r) begin
      paused_r <= 1'b0;
    end else if (pr_fall && !sck_s) begin
      paused_r <= 1'b1;
    end else if (pr_rise && !sck_s) begin
      paused_r <= 1'b0;
    end
  end

  assign quad = quad_cmd & qe_r;
  assign active = frame & ~paused_r & ~hw_reset_r;
  assign cnt_nxt = cnt_r + (quad ? sfpi_pkg::STEP_QUAD
                                 : sfpi_pkg::STEP_SINGLE);
  assign rx_sh_nxt = sfpi_pkg::shift_in(rx_sh_r, lanes[sfpi_pkg::LANE_SI],
                                        lanes, quad);

  // bit progress is left untouched across a pause
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= sfpi_pkg::CNT_ZERO;
      rx_sh_r <= 8'h00;
    end else if (!frame || hw_reset_r) begin
      cnt_r <= sfpi_pkg::CNT_ZERO;
    end else if (active && sck_rise) begin
      cnt_r <= cnt_nxt;
      rx_sh_r <= rx_sh_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_valid_r <= 1'b0;
      rx_data_r <= 8'h00;
    end else begin
      rx_valid_r <= active & sck_rise & (cnt_nxt == sfpi_pkg::CNT_ZERO);
      if (active && sck_rise && cnt_nxt == sfpi_pkg::CNT_ZERO) begin
        rx_data_r <= rx_sh_nxt;
      end
    end
  end

  // next byte is loaded at the first falling edge after a full byte
  // lanes follow this value, so a new bit leaves before the next rise
  always_comb begin
    tx_sh_nxt = tx_sh_r;
    if (cs_fall) begin
      tx_sh_nxt = tx_data;
    end else if (active && sck_fall) begin
      tx_sh_nxt = load_r ? tx_data
                         : sfpi_pkg::shift_out(tx_sh_r, quad);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_sh_r <= 8'h00;
      load_r <= 1'b0;
    end else begin
      tx_sh_r <= tx_sh_nxt;
      if (cs_fall || (active && sck_fall)) begin
        load_r <= 1'b0;
      end else if (active && sck_rise && cnt_nxt == sfpi_pkg::CNT_ZERO) begin
        load_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dev_oe_r <= sfpi_pkg::OE_NONE;
      dev_o_r <= 4'h0;
    end else begin
      if (!(active && tx_en)) begin
        dev_oe_r <= sfpi_pkg::OE_NONE;
      end else if (quad) begin
        dev_oe_r <= sfpi_pkg::OE_QUAD;
      end else begin
        dev_oe_r <= sfpi_pkg::OE_SINGLE;
      end
      dev_o_r <= quad ? tx_sh_nxt[7:4]
                      : {2'b00, tx_sh_nxt[7], 1'b0};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      selected_r <= 1'b0;
    end else begin
      selected_r <= frame;
    end
  end

  assign link.dev_o = dev_o_r;
  assign link.dev_oe = dev_oe_r;
  assign rx_valid = rx_valid_r;
  assign rx_data = rx_data_r;
  assign selected = selected_r;
  assign paused = paused_r;
  assign hw_reset = hw_reset_r;
  assign status_write_allowed = swa_r;
endmodule : sfpi_device

/* File: hw/sfpi_host.sv */
// host controller end: AXI4-Lite registers driving the flash pin link
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
module sfpi_host (
  input wire logic aclk,
  input wire logic aresetn,
  sfpi_if.host link,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [3:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  logic awready_r, aw_have_r, wready_r, w_have_r, bvalid_r;
  logic [3:0] awaddr_r;
  logic [31:0] wdata_r;
  logic wstrb0_r;
  logic [1:0] bresp_r;
  logic arready_r, rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic do_write;
  logic [sfpi_pkg::CTRL_W-1:0] ctrl_r;
  logic [7:0] tx_byte_r;
  logic start_r;
  sfpi_pkg::sfpi_host_state_type state_r;
  logic [sfpi_pkg::HALF_W-1:0] half_r;
  logic [3:0] groups_r;
  logic [7:0] tx_sh_r, rx_sh_r, rx_byte_r;
  logic [3:0] io_meta_r, io_sync_r;
  logic sck_r, csn_r;
  logic [3:0] ho_r, hoe_r, ho_nxt, hoe_nxt;
  logic quad, busy;

  assign do_write = aw_have_r & w_have_r & ~bvalid_r;
  assign quad = ctrl_r[sfpi_pkg::CTRL_QUAD];
  assign busy = start_r | (state_r != sfpi_pkg::SFPI_IDLE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      aw_have_r <= 1'b0;
      awaddr_r <= 4'h0;
    end else if (s_axi_awvalid && awready_r) begin
      aw_have_r <= 1'b1;
      awready_r <= 1'b0;
      awaddr_r <= s_axi_awaddr;
    end else if (do_write) begin
      aw_have_r <= 1'b0;
    end else begin
      awready_r <= ~aw_have_r & ~bvalid_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_r <= 1'b0;
      w_have_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb0_r <= 1'b0;
    end else if (s_axi_wvalid && wready_r) begin
      w_have_r <= 1'b1;
      wready_r <= 1'b0;
      wdata_r <= s_axi_wdata;
      wstrb0_r <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_have_r <= 1'b0;
    end else begin
      wready_r <= ~w_have_r & ~bvalid_r;
    end
  end

  // all fields live in byte lane 0; a TX write while busy is dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= sfpi_pkg::RESP_OKAY;
      ctrl_r <= '0;
      tx_byte_r <= 8'h00;
      start_r <= 1'b0;
    end else begin
      if (state_r != sfpi_pkg::SFPI_IDLE) begin
        start_r <= 1'b0;
      end
      if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
      if (do_write) begin
        bvalid_r <= 1'b1;
        bresp_r <= sfpi_pkg::RESP_OKAY;
        case (awaddr_r)
          sfpi_pkg::REG_CTRL: begin
            if (wstrb0_r) begin
              ctrl_r <= wdata_r[sfpi_pkg::CTRL_W-1:0];
            end
          end
          sfpi_pkg::REG_TX: begin
            if (wstrb0_r && !busy && ctrl_r[sfpi_pkg::CTRL_CS]) begin
              tx_byte_r <= wdata_r[7:0];
              start_r <= 1'b1;
            end
          end
          sfpi_pkg::REG_RX, sfpi_pkg::REG_STATUS: begin
          end
          default: begin
            bresp_r <= sfpi_pkg::RESP_SLVERR;
          end
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= sfpi_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
      rresp_r <= sfpi_pkg::RESP_OKAY;
      case (s_axi_araddr)
        sfpi_pkg::REG_CTRL: rdata_r[sfpi_pkg::CTRL_W-1:0] <= ctrl_r;
        sfpi_pkg::REG_TX: rdata_r[7:0] <= tx_byte_r;
        sfpi_pkg::REG_RX: rdata_r[7:0] <= rx_byte_r;
        sfpi_pkg::REG_STATUS: begin
          rdata_r[sfpi_pkg::STAT_BUSY] <= busy;
          rdata_r[sfpi_pkg::STAT_CS] <= ~csn_r;
        end
        default: rresp_r <= sfpi_pkg::RESP_SLVERR;
      endcase
    end else if (rvalid_r) begin
      rvalid_r <= ~s_axi_rready;
    end else begin
      arready_r <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      io_meta_r <= 4'hF;
      io_sync_r <= 4'hF;
    end else begin
      io_meta_r <= link.io;
      io_sync_r <= io_meta_r;
    end
  end

  // sampling at the end of the high phase leaves margin for sync delay
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= sfpi_pkg::SFPI_IDLE;
      half_r <= '0;
      groups_r <= 4'h0;
      tx_sh_r <= 8'h00;
      rx_sh_r <= 8'h00;
      rx_byte_r <= 8'h00;
      sck_r <= 1'b0;
      csn_r <= 1'b1;
    end else begin
      case (state_r)
        sfpi_pkg::SFPI_IDLE: begin
          csn_r <= ~ctrl_r[sfpi_pkg::CTRL_CS];
          half_r <= '0;
          if (start_r) begin
            tx_sh_r <= tx_byte_r;
            groups_r <= quad ? sfpi_pkg::GROUPS_QUAD
                             : sfpi_pkg::GROUPS_SINGLE;
            state_r <= sfpi_pkg::SFPI_LOW;
          end
        end
        sfpi_pkg::SFPI_LOW: begin
          half_r <= half_r + 1'b1;
          if (half_r == sfpi_pkg::HALF_LAST) begin
            half_r <= '0;
            sck_r <= 1'b1;
            state_r <= sfpi_pkg::SFPI_HIGH;
          end
        end
        sfpi_pkg::SFPI_HIGH: begin
          half_r <= half_r + 1'b1;
          if (half_r == sfpi_pkg::HALF_LAST) begin
            half_r <= '0;
            sck_r <= 1'b0;
            rx_sh_r <= sfpi_pkg::shift_in(rx_sh_r,
                         io_sync_r[sfpi_pkg::LANE_SO], io_sync_r, quad);
            tx_sh_r <= sfpi_pkg::shift_out(tx_sh_r, quad);
            groups_r <= groups_r - 1'b1;
            if (groups_r == sfpi_pkg::GROUPS_LAST) begin
              rx_byte_r <= sfpi_pkg::shift_in(rx_sh_r,
                             io_sync_r[sfpi_pkg::LANE_SO], io_sync_r, quad);
              state_r <= sfpi_pkg::SFPI_IDLE;
            end else begin
              state_r <= sfpi_pkg::SFPI_LOW;
            end
          end
        end
        default: begin
          state_r <= sfpi_pkg::SFPI_IDLE;
        end
      endcase
    end
  end

  // guard and pause drive only outside quad mode, pause only with clock low
  always_comb begin
    ho_nxt = {1'b0, 1'b0, 1'b0, tx_sh_r[7]};
    hoe_nxt = {ctrl_r[sfpi_pkg::CTRL_PR_LOW],
               ctrl_r[sfpi_pkg::CTRL_WG_LOW], 1'b0,
               ctrl_r[sfpi_pkg::CTRL_CS]};
    if (quad) begin
      ho_nxt = tx_sh_r[7:4];
      hoe_nxt = ctrl_r[sfpi_pkg::CTRL_READ] ? sfpi_pkg::OE_NONE
                                            : sfpi_pkg::OE_QUAD;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ho_r <= 4'h0;
      hoe_r <= sfpi_pkg::OE_NONE;
    end else if (state_r != sfpi_pkg::SFPI_HIGH) begin
      ho_r <= ho_nxt;
      hoe_r <= hoe_nxt;
    end
  end

  assign link.sck = sck_r;
  assign link.cs_n = csn_r;
  assign link.host_o = ho_r;
  assign link.host_oe = hoe_r;
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
endmodule : sfpi_host

/* File: verification/sfpi_chk.sv */
// pin-level checks on the link joining host and flash ends
module sfpi_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] host_o,
  input wire logic [3:0] host_oe,
  input wire logic [3:0] dev_o,
  input wire logic [3:0] dev_oe,
  input wire logic [3:0] io
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // device sees the pins late, so allow its sync stages to drain
  oe_release_a: assert property (cs_n [*4] |-> dev_oe == 4'h0)
    else $error("device drives lanes while deselected");
  out_shift_a: assert property (
    dev_oe[1] && $changed(dev_o[1]) |-> !sck)
    else $error("serial output moved while link clock high");
  sck_high_a: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
    else $error("link clock high phase has wrong length");
  idle_clock_a: assert property (cs_n |-> !sck)
    else $error("link clock runs outside a frame");
  cs_edge_a: assert property (
    $changed(cs_n) |-> !sck && !$past(sck))
    else $error("select moved near a clock high phase");
  si_hold_a: assert property (
    sck && $past(sck) |-> $stable(host_o[0]))
    else $error("serial input moved while clock high");
  pause_edge_a: assert property (sck && $past(sck) |->
    $stable(host_o[3]) && $stable(host_oe[3]))
    else $error("lane three moved while clock high");
  guard_pull_a: assert property (!dev_oe[2] && !host_oe[2] |-> io[2])
    else $error("floating guard lane not high");
  pause_pull_a: assert property (!dev_oe[3] && !host_oe[3] |-> io[3])
    else $error("floating lane three not high");
  no_fight_a: assert property ((dev_oe & host_oe) == 4'h0)
    else $error("both ends drive one lane");
endmodule : sfpi_chk

/* File: verification/tb_top.sv */
// self-checking bench: host and flash ends joined over the pin link
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, quad_io_enable, status_protect_bit_1;
  logic status_protect_bit_0, pause_or_restart_select, quad_cmd, tx_en;
  logic [7:0] tx_data, rx_data;
  logic rx_valid, selected, paused, hw_reset, status_write_allowed;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int mismatches, total_checks, rx_count, n0;

  sfpi_if link ();
  sfpi_device sfpi_device_inst (.aclk(aclk), .aresetn(aresetn), .link(link),
    .quad_io_enable(quad_io_enable),
    .status_protect_bit_1(status_protect_bit_1),
    .status_protect_bit_0(status_protect_bit_0),
    .pause_or_restart_select(pause_or_restart_select),
    .quad_cmd(quad_cmd), .tx_en(tx_en), .tx_data(tx_data),
    .rx_valid(rx_valid), .rx_data(rx_data), .selected(selected),
    .paused(paused), .hw_reset(hw_reset),
    .status_write_allowed(status_write_allowed));
  sfpi_host sfpi_host_inst (.aclk(aclk), .aresetn(aresetn), .link(link),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp));
  sfpi_chk sfpi_chk_inst (.aclk(aclk), .aresetn(aresetn), .sck(link.sck),
    .cs_n(link.cs_n), .host_o(link.host_o), .host_oe(link.host_oe),
    .dev_o(link.dev_o), .dev_oe(link.dev_oe), .io(link.io));

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    if (rx_valid === 1'b1) rx_count++;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v,
                        input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task automatic ctrl(input logic [4:0] c);
    axi_wr(sfpi_pkg::REG_CTRL, {27'h000_0000, c}, sfpi_pkg::RESP_OKAY);
  endtask : ctrl

  // one byte; c holds the control bits, cs included
  task automatic xfer(input logic [4:0] c, input logic qe, input logic te);
    logic [7:0] b, t;
    logic got_byte;
    seed = xs(seed);
    b = seed[7:0];
    t = seed[15:8];
    got_byte = !c[1] || qe;
    quad_io_enable <= qe;
    quad_cmd <= c[1];
    tx_en <= te;
    tx_data <= t;
    ctrl(c);
    n0 = rx_count;
    axi_wr(sfpi_pkg::REG_TX, {24'h00_0000, b}, sfpi_pkg::RESP_OKAY);
    do axi_rd(sfpi_pkg::REG_STATUS); while (d[0] !== 1'b0);
    chk(d[1], 1'b1);
    if (!c[2]) chk(rx_count - n0, got_byte);
    if (!c[2] && got_byte) chk(rx_data, b);
    axi_rd(sfpi_pkg::REG_RX);
    if (te && got_byte) chk(d[7:0], t);
    ctrl(5'h00);
  endtask : xfer

  // roles latch while deselected, then the host pulls a lane low
  task automatic role(input logic [4:0] low, input logic [2:0] q,
                      input logic sel);
    quad_io_enable <= q[2];
    status_protect_bit_1 <= q[1];
    status_protect_bit_0 <= q[0];
    pause_or_restart_select <= sel;
    ctrl(5'h01);
    ctrl(low | 5'h01);
    repeat (8) @(posedge aclk);
  endtask : role

  initial begin
    {aresetn, quad_io_enable, status_protect_bit_1, quad_cmd} = 4'h0;
    {status_protect_bit_0, pause_or_restart_select, tx_en} = 3'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, tx_data} = 16'h0000;
    s_axi_wstrb = 4'hF;
    s_axi_wdata = 32'h0000_0000;
    {mismatches, total_checks, rx_count} = '0;
    seed = 32'h782f_e18f;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    for (int i = 0; i < 4; i++) begin
      role(5'h08, {1'b0, 2'(i)}, 1'b0);
      chk(status_write_allowed, i != 1);
      ctrl(5'h00);
    end
    role(5'h10, 3'h0, 1'b0);
    chk(paused, 1'b1);
    chk(selected, 1'b1);
    pause_or_restart_select <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(hw_reset, 1'b0);
    ctrl(5'h01);
    repeat (8) @(posedge aclk);
    chk(paused, 1'b0);
    ctrl(5'h00);
    role(5'h10, 3'h0, 1'b1);
    chk(hw_reset, 1'b1);
    chk(paused, 1'b0);
    ctrl(5'h00);
    seed = xs(seed);
    axi_wr(4'h2, seed, sfpi_pkg::RESP_SLVERR);
    axi_rd(4'h2);
    chk(r, sfpi_pkg::RESP_SLVERR);
    chk(d, 32'h0000_0000);
    n0 = rx_count;
    axi_wr(sfpi_pkg::REG_TX, seed, sfpi_pkg::RESP_OKAY);
    axi_rd(sfpi_pkg::REG_STATUS);
    chk(d[1:0], 2'h0);
    chk(rx_count, n0);
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      case (i < 4 ? 2'(i) : seed[17:16])
        2'h0: xfer(5'h01, seed[18], seed[19]);
        2'h1: xfer(5'h03, 1'b1, 1'b0);
        2'h2: xfer(5'h07, 1'b1, 1'b1);
        default: xfer(5'h03, 1'b0, 1'b0);
      endcase
    end
    conclude();
  end

  initial begin
    repeat (40000) @(posedge aclk);
    mismatches++;
    $display("BAD %0t watchdog expired", $time);
    conclude();
  end
endmodule : tb_top
